// File: hdl/ift_axil_slave.sv
`include "ift_cfg.svh"
module ift_axil_slave (
   input wire logic clk,
   input wire logic reset_n,
   input wire ift_pkg::ift_axil_req_t req,
   output ift_pkg::ift_axil_rsp_t rsp,
   output logic wr_go,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_go,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_held_r;
   logic w_held_r;
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // --------------------------------------------------------------
   // write channel: address and data taken in either order
   // --------------------------------------------------------------
   assign wr_go = aw_held_r & w_held_r & ~rsp.bvalid;
   assign wr_addr = awaddr_r;
   assign wr_data = wdata_r;
   assign wr_strb = wstrb_r;
   assign rd_go = req.arvalid & rsp.arready;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         rsp.awready <= 1'b0;
         rsp.wready <= 1'b0;
         rsp.bvalid <= 1'b0;
         rsp.bresp <= `IFT_RESP_OKAY;
      end else begin
         // ready only while the holding slot is free
         rsp.awready <= ~aw_held_r & ~(req.awvalid & rsp.awready);
         rsp.wready <= ~w_held_r & ~(req.wvalid & rsp.wready);
         if (req.awvalid & rsp.awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= req.awaddr;
         end
         if (req.wvalid & rsp.wready) begin
            w_held_r <= 1'b1;
            wdata_r <= req.wdata;
            wstrb_r <= req.wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            rsp.bvalid <= 1'b1;
            rsp.bresp <= wr_err ? `IFT_RESP_SLVERR : `IFT_RESP_OKAY;
         end else if (rsp.bvalid & req.bready) begin
            rsp.bvalid <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // read channel: one read in flight, data latched at acceptance
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rsp.arready <= 1'b0;
         rsp.rvalid <= 1'b0;
         rsp.rdata <= 32'h0000_0000;
         rsp.rresp <= `IFT_RESP_OKAY;
      end else begin
         if (rd_go) begin
            rsp.arready <= 1'b0;
            rsp.rvalid <= 1'b1;
            rsp.rdata <= rd_data;
            rsp.rresp <= rd_err ? `IFT_RESP_SLVERR : `IFT_RESP_OKAY;
         end else if (rsp.rvalid & req.rready) begin
            rsp.rvalid <= 1'b0;
         end else if (!rsp.rvalid) begin
            rsp.arready <= 1'b1;
         end
      end
   end
endmodule

// File: hdl/ift_cfg.svh
`ifndef IFT_CFG_SVH
`define IFT_CFG_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define IFT_ADDR_RECEIVE_THRESHOLD_FIELD 32'h5000_1438
`define IFT_ADDR_TX_TL 32'h5000_143C
`define IFT_ADDR_CLR_ALL 32'h5000_1440
`define IFT_ADDR_CLR_RXU 32'h5000_1444
`define IFT_ADDR_CLR_RXO 32'h5000_1448
`define IFT_ADDR_CLR_TXO 32'h5000_144C
`define IFT_ADDR_CLR_RDQ 32'h5000_1450
`define IFT_ADDR_CLR_ABT 32'h5000_1454
`define IFT_ADDR_IRQ_STAT 32'h5000_1480
`define IFT_ADDR_IRQ_MASK 32'h5000_1484
`define IFT_ADDR_RAW 32'h5000_1488
`define IFT_ADDR_ABT_SRC 32'h5000_148C
// ----------------------------------------------------------------
// raw flag positions and the kept abort source bit
// ----------------------------------------------------------------
`define IFT_B_RXU 0
`define IFT_B_RXO 1
`define IFT_B_RXL 2
`define IFT_B_TXO 3
`define IFT_B_TXL 4
`define IFT_B_RDQ 5
`define IFT_B_ABT 6
`define IFT_B_SRC_KEEP 9
// ----------------------------------------------------------------
// sizes, reset values and response codes
// ----------------------------------------------------------------
`define IFT_TL_MAX 5'h1F
`define IFT_DEPTH 6'h20
`define IFT_TL_RST 5'h00
`define IFT_MASK_RST 7'h00
`define IFT_RESP_OKAY 2'b00
`define IFT_RESP_SLVERR 2'b10
`endif

// File: hdl/ift_pkg.sv
package ift_pkg;
   // axi4-lite master to slave
   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } ift_axil_req_t;
   // axi4-lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ift_axil_rsp_t;
   // one-cycle event pulses from the protocol engine
   typedef struct packed {
      logic rx_under;
      logic rx_over;
      logic tx_over;
      logic rd_req;
      logic transmit_abort_flag;
   } ift_evt_t;
endpackage

// File: hdl/ift_top.sv
// Chosen here: the AXI4-Lite interface to the registers.
`include "ift_cfg.svh"
module ift_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire ift_pkg::ift_axil_req_t axil_req,
   output ift_pkg::ift_axil_rsp_t axil_rsp,
   input wire logic [5:0] rx_fifo_level,
   input wire logic [5:0] tx_fifo_level,
   input wire ift_pkg::ift_evt_t evt,
   input wire logic [15:0] abrt_src_set,
   input wire logic abrt_keep,
   output logic [15:0] raw_intr_r,
   output logic [15:0] abrt_src_r,
   output logic tx_flush_r,
   output logic irq_r
);
   logic wr_go;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic rd_go;
   logic [31:0] rd_data;
   logic rd_err;
   logic [4:0] receive_threshold_field_r;
   logic [4:0] tx_tl_r;
   logic [6:0] irq_stat_r;
   logic [6:0] irq_mask_r;
   logic [6:0] flag_set;
   logic [6:0] flag_clr;
   logic rx_lvl_nxt;
   logic tx_lvl_nxt;
   logic [5:0] rx_entries;
   logic [5:0] tx_entries;
   logic [15:0] tl_new;

   // --------------------------------------------------------------
   // bus slave
   // --------------------------------------------------------------
   ift_axil_slave u_slave (
      .clk(clk),
      .reset_n(reset_n),
      .req(axil_req),
      .rsp(axil_rsp),
      .wr_go(wr_go),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_go(rd_go),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // --------------------------------------------------------------
   // decode helpers
   // --------------------------------------------------------------
   // raw flags that a read at this address clears
   function automatic logic [6:0] clr_bits(input logic [31:0] a);
      logic [6:0] m;
      m = 7'h00;
      case (a)
         `IFT_ADDR_CLR_ALL: begin
            m[`IFT_B_RXU] = 1'b1;
            m[`IFT_B_RXO] = 1'b1;
            m[`IFT_B_TXO] = 1'b1;
            m[`IFT_B_RDQ] = 1'b1;
            m[`IFT_B_ABT] = 1'b1; // level bits stay out
         end
         `IFT_ADDR_CLR_RXU: m[`IFT_B_RXU] = 1'b1;
         `IFT_ADDR_CLR_RXO: m[`IFT_B_RXO] = 1'b1;
         `IFT_ADDR_CLR_TXO: m[`IFT_B_TXO] = 1'b1;
         `IFT_ADDR_CLR_RDQ: m[`IFT_B_RDQ] = 1'b1;
         `IFT_ADDR_CLR_ABT: m[`IFT_B_ABT] = 1'b1;
         default: m = 7'h00;
      endcase
      return m;
   endfunction

   // true for an address that this block answers
   function automatic logic is_mapped(input logic [31:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         `IFT_ADDR_RECEIVE_THRESHOLD_FIELD, `IFT_ADDR_TX_TL, `IFT_ADDR_CLR_ALL,
         `IFT_ADDR_CLR_RXU, `IFT_ADDR_CLR_RXO, `IFT_ADDR_CLR_TXO,
         `IFT_ADDR_CLR_RDQ, `IFT_ADDR_CLR_ABT, `IFT_ADDR_IRQ_STAT,
         `IFT_ADDR_IRQ_MASK, `IFT_ADDR_RAW, `IFT_ADDR_ABT_SRC:
            hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // merge a write into a 16-bit register by byte lane
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      return v;
   endfunction

   // --------------------------------------------------------------
   // read mux; clear registers show the flag before it is cleared
   // --------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000; // reserved bits read zero
      rd_err = 1'b0;
      case (axil_req.araddr)
         `IFT_ADDR_RECEIVE_THRESHOLD_FIELD: rd_data[4:0] = receive_threshold_field_r;
         `IFT_ADDR_TX_TL: rd_data[4:0] = tx_tl_r;
         `IFT_ADDR_CLR_ALL:
            rd_data[0] = |(raw_intr_r[6:0] & clr_bits(`IFT_ADDR_CLR_ALL));
         `IFT_ADDR_CLR_RXU: rd_data[0] = raw_intr_r[`IFT_B_RXU];
         `IFT_ADDR_CLR_RXO: rd_data[0] = raw_intr_r[`IFT_B_RXO];
         `IFT_ADDR_CLR_TXO: rd_data[0] = raw_intr_r[`IFT_B_TXO];
         `IFT_ADDR_CLR_RDQ: rd_data[0] = raw_intr_r[`IFT_B_RDQ];
         `IFT_ADDR_CLR_ABT: rd_data[0] = raw_intr_r[`IFT_B_ABT];
         `IFT_ADDR_IRQ_STAT: rd_data[6:0] = irq_stat_r;
         `IFT_ADDR_IRQ_MASK: rd_data[6:0] = irq_mask_r;
         `IFT_ADDR_RAW: rd_data[15:0] = raw_intr_r;
         `IFT_ADDR_ABT_SRC: rd_data[15:0] = abrt_src_r;
         default: rd_err = 1'b1;
      endcase
   end

   // writes to the read-only or clear registers are accepted, ignored
   assign wr_err = ~is_mapped(wr_addr);

   // --------------------------------------------------------------
   // threshold registers
   // --------------------------------------------------------------
   // a write of more than the largest code (31) is clamped, not masked
   assign tl_new = wr_addr == `IFT_ADDR_RECEIVE_THRESHOLD_FIELD ?
                   merge16({11'h000, receive_threshold_field_r}, wr_data, wr_strb) :
                   merge16({11'h000, tx_tl_r}, wr_data, wr_strb);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         receive_threshold_field_r <= `IFT_TL_RST;
         tx_tl_r <= `IFT_TL_RST;
      end else if (wr_go) begin
         if (wr_addr == `IFT_ADDR_RECEIVE_THRESHOLD_FIELD) begin
            receive_threshold_field_r <= tl_new > 16'(`IFT_TL_MAX) ? `IFT_TL_MAX
                                                 : tl_new[4:0];
         end
         if (wr_addr == `IFT_ADDR_TX_TL) begin
            tx_tl_r <= tl_new > 16'(`IFT_TL_MAX) ? `IFT_TL_MAX
                                                 : tl_new[4:0];
         end
      end
   end

   // --------------------------------------------------------------
   // level flags, recomputed every cycle so they fall by themselves
   // --------------------------------------------------------------
   assign rx_entries = 6'(receive_threshold_field_r) + 6'h01;
   // top code reaches the full depth of 32 entries
   assign tx_entries = tx_tl_r == `IFT_TL_MAX ? `IFT_DEPTH
                                              : 6'(tx_tl_r);
   assign rx_lvl_nxt = rx_fifo_level >= rx_entries;
   assign tx_lvl_nxt = tx_fifo_level <= tx_entries;

   // --------------------------------------------------------------
   // sticky raw flags; a set in the clearing cycle wins
   // --------------------------------------------------------------
   assign flag_clr = rd_go ? clr_bits(axil_req.araddr) : 7'h00;

   always_comb begin
      flag_set = 7'h00;
      flag_set[`IFT_B_RXU] = evt.rx_under;
      flag_set[`IFT_B_RXO] = evt.rx_over;
      flag_set[`IFT_B_TXO] = evt.tx_over;
      flag_set[`IFT_B_RDQ] = evt.rd_req;
      flag_set[`IFT_B_ABT] = evt.transmit_abort_flag;
      flag_set[`IFT_B_RXL] = rx_lvl_nxt & ~raw_intr_r[`IFT_B_RXL];
      flag_set[`IFT_B_TXL] = tx_lvl_nxt & ~raw_intr_r[`IFT_B_TXL];
   end

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_flag
         if (gi == `IFT_B_RXL || gi == `IFT_B_TXL) begin : g_lvl
            // level flags follow the FIFO, no software clear
            always_ff @(posedge clk) begin
               if (!reset_n) begin
                  raw_intr_r[gi] <= 1'b0;
               end else begin
                  raw_intr_r[gi] <= gi == `IFT_B_RXL ? rx_lvl_nxt
                                                     : tx_lvl_nxt;
               end
            end
         end else begin : g_sw
            always_ff @(posedge clk) begin
               if (!reset_n) begin
                  raw_intr_r[gi] <= 1'b0;
               end else if (flag_set[gi]) begin
                  raw_intr_r[gi] <= 1'b1;
               end else if (flag_clr[gi]) begin
                  raw_intr_r[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // upper raw bits belong to other parts of the unit
   assign raw_intr_r[15:7] = 9'h000;

   // --------------------------------------------------------------
   // abort source: bit 9 is kept while its cause still holds
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         abrt_src_r <= 16'h0000;
      end else if (flag_clr[`IFT_B_ABT]) begin
         abrt_src_r <= abrt_src_set;
         if (abrt_keep) begin
            abrt_src_r[`IFT_B_SRC_KEEP] <= abrt_src_r[`IFT_B_SRC_KEEP] |
                                           abrt_src_set[`IFT_B_SRC_KEEP];
         end
      end else begin
         abrt_src_r <= abrt_src_r | abrt_src_set;
      end
   end

   // --------------------------------------------------------------
   // transmit FIFO flush hold
   // --------------------------------------------------------------
   // held from the abort until software reads the abort clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_flush_r <= 1'b0;
      end else if (evt.transmit_abort_flag) begin
         tx_flush_r <= 1'b1;
      end else if (rd_go && axil_req.araddr == `IFT_ADDR_CLR_ABT) begin
         tx_flush_r <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // interrupt status, mask and output
   // --------------------------------------------------------------
   // status bits are write-one-to-clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_stat_r <= 7'h00;
      end else begin
         irq_stat_r <= flag_set | (irq_stat_r & ~(
            (wr_go && wr_addr == `IFT_ADDR_IRQ_STAT && wr_strb[0]) ?
            wr_data[6:0] : 7'h00));
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_mask_r <= `IFT_MASK_RST;
      end else if (wr_go && wr_addr == `IFT_ADDR_IRQ_MASK && wr_strb[0]) begin
         irq_mask_r <= wr_data[6:0]; // upper bits dropped
      end
   end

   // registered, so it follows the status by one cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_RECEIVE_THRESHOLD_FIELD_CLAMP: assert property (
      wr_go && wr_addr == `IFT_ADDR_RECEIVE_THRESHOLD_FIELD && tl_new > 16'h001F
      |=> receive_threshold_field_r == 5'h1F)
      else $error("receive threshold not clamped");
   AST_TX_TL_CLAMP: assert property (
      wr_go && wr_addr == `IFT_ADDR_TX_TL && tl_new > 16'h001F
      |=> tx_tl_r == 5'h1F)
      else $error("transmit threshold not clamped");
   AST_RX_LEVEL: assert property (
      raw_intr_r[2] == ($past(rx_fifo_level) > {1'b0, $past(receive_threshold_field_r)}))
      else $error("receive level flag wrong");
   AST_TX_LEVEL_FULL: assert property (
      tx_tl_r == 5'h1F && tx_fifo_level == 6'h20 |=> raw_intr_r[4])
      else $error("transmit flag missing at 32 entries");
   AST_TX_LEVEL_DROP: assert property (
      tx_tl_r == 5'h00 && tx_fifo_level == 6'h01 |=> !raw_intr_r[4])
      else $error("transmit level flag stuck");
   AST_CLR_ALL: assert property (
      rd_go && axil_req.araddr == `IFT_ADDR_CLR_ALL && evt == 5'h00
      |=> raw_intr_r[6:5] == 2'b00 && raw_intr_r[3] == 1'b0
          && raw_intr_r[1:0] == 2'b00)
      else $error("combined clear missed a flag");
   AST_CLR_ALL_LVL: assert property (
      rd_go && axil_req.araddr == `IFT_ADDR_CLR_ALL && rx_lvl_nxt
      |=> raw_intr_r[2])
      else $error("combined clear hit a level flag");
   AST_KEEP_SRC9: assert property (
      flag_clr[6] && abrt_keep && abrt_src_r[9] |=> abrt_src_r[9])
      else $error("abort source bit 9 lost");
   AST_CLR_RDQ: assert property (
      rd_go && axil_req.araddr == `IFT_ADDR_CLR_RDQ && !evt.rd_req
      |=> !raw_intr_r[5] && raw_intr_r[1] == $past(raw_intr_r[1])
          || $past(evt.rx_over))
      else $error("read request clear wrong");
   AST_SET_WINS: assert property (
      flag_clr[0] && evt.rx_under |=> raw_intr_r[0])
      else $error("underrun event lost under clear");
   AST_FLUSH_HOLD: assert property (
      tx_flush_r && !(rd_go && axil_req.araddr == `IFT_ADDR_CLR_ABT)
      |=> tx_flush_r)
      else $error("flush released without abort clear");
   AST_FLUSH_REL: assert property (
      rd_go && axil_req.araddr == `IFT_ADDR_CLR_ABT && !evt.transmit_abort_flag
      |=> !tx_flush_r ##1 !tx_flush_r || $past(evt.transmit_abort_flag))
      else $error("flush not released");
   AST_RSVD_ZERO: assert property (
      axil_rsp.rvalid |-> axil_rsp.rdata[31:16] == 16'h0000)
      else $error("reserved read bits not zero");
endmodule

// File: verif/i2c_fifo_threshold_intr_clear_tb_top.sv
`include "ift_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module i2c_fifo_threshold_intr_clear_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, abrt_keep, tx_flush_r, irq_r;
   ift_pkg::ift_axil_req_t axil_req;
   ift_pkg::ift_axil_rsp_t axil_rsp;
   ift_pkg::ift_evt_t evt;
   logic [5:0] rx_tgt, tx_tgt, rx_fifo_level, tx_fifo_level;
   logic [15:0] abrt_src_set, raw_intr_r, abrt_src_r, lv, bef;
   logic [31:0] rd, d, clra [5];
   logic [1:0] rs;
   int err_total, num_checks, seed, t, l, offs [5];
   // ----------------------------------------------------------------
   // clock, instances, watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ift_top u_ift_top (.clk(clk), .reset_n(reset_n), .axil_req(axil_req),
      .axil_rsp(axil_rsp), .rx_fifo_level(rx_fifo_level),
      .tx_fifo_level(tx_fifo_level), .evt(evt), .abrt_src_set(abrt_src_set),
      .abrt_keep(abrt_keep), .raw_intr_r(raw_intr_r),
      .abrt_src_r(abrt_src_r), .tx_flush_r(tx_flush_r), .irq_r(irq_r));
   ift_eng_model u_ift_eng_model (.clk(clk), .reset_n(reset_n),
      .rx_tgt(rx_tgt), .tx_tgt(tx_tgt), .tx_flush_r(tx_flush_r),
      .rx_lvl(rx_fifo_level), .tx_lvl(tx_fifo_level));
   // the whole run needs well under a tenth of this span
   initial begin
      #(40 * 40000);
      err_total++;
      test_done();
   end
   // ----------------------------------------------------------------
   // bus tasks and expectations
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // address and data offered together, each dropped once taken
   task automatic axw(input logic [31:0] a, input logic [31:0] v);
      int c;
      axil_req.awaddr <= a;
      axil_req.wdata <= v;
      axil_req.wstrb <= 4'hF;
      axil_req.awvalid <= 1'b1;
      axil_req.wvalid <= 1'b1;
      axil_req.bready <= 1'b1;
      for (c = 0; c < 100; c++) begin
         @(posedge clk);
         if (axil_req.awvalid && axil_rsp.awready) axil_req.awvalid <= 1'b0;
         if (axil_req.wvalid && axil_rsp.wready) axil_req.wvalid <= 1'b0;
         if (axil_rsp.bvalid) break;
      end
      rs = axil_rsp.bresp;
      axil_req.bready <= 1'b0;
      if (c == 100) err_total++;
      @(posedge clk);
   endtask
   task automatic axr(input logic [31:0] a);
      int c;
      axil_req.araddr <= a;
      axil_req.arvalid <= 1'b1;
      axil_req.rready <= 1'b1;
      for (c = 0; c < 100; c++) begin
         @(posedge clk);
         if (axil_req.arvalid && axil_rsp.arready) axil_req.arvalid <= 1'b0;
         if (axil_rsp.rvalid) break;
      end
      rd = axil_rsp.rdata;
      rs = axil_rsp.rresp;
      axil_req.rready <= 1'b0;
      if (c == 100) err_total++;
      @(posedge clk);
   endtask
   task automatic lvl_set(input int r, input int x);
      rx_tgt <= r[5:0];
      tx_tgt <= x[5:0];
      for (int c = 0; c < 80; c++) begin
         @(posedge clk);
         if (rx_fifo_level == r[5:0] && tx_fifo_level == x[5:0]) break;
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic pulse(input logic [4:0] e, input logic [15:0] s);
      evt <= e;
      abrt_src_set <= s;
      @(posedge clk);
      evt <= '0;
      abrt_src_set <= '0;
      repeat (2) @(posedge clk);
   endtask
   // writes beyond code 31 keep the largest code
   function automatic logic [31:0] clamp(input logic [31:0] v);
      return (v[15:0] > 16'h001F) ? 32'h0000_001F : {27'h0, v[4:0]};
   endfunction
   function automatic logic rx_on(input int lvl, input int code);
      return lvl >= code + 1;
   endfunction
   function automatic logic tx_on(input int lvl, input int code);
      return lvl <= ((code == 31) ? 32 : code);
   endfunction
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      axil_req = '0;
      evt = '0;
      abrt_src_set = 16'h0000;
      abrt_keep = 1'b0;
      rx_tgt = 6'h00;
      tx_tgt = 6'h00;
      reset_n = 1'b0;
      seed = 28605;
      clra = '{`IFT_ADDR_CLR_RXU, `IFT_ADDR_CLR_RXO, `IFT_ADDR_CLR_TXO,
         `IFT_ADDR_CLR_RDQ, `IFT_ADDR_CLR_ABT};
      offs = '{-1, 0, 1, 2, -1};
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(irq_r, 1'b0)
      axr(`IFT_ADDR_RECEIVE_THRESHOLD_FIELD);
      `CHK(rd, 32'h0000_0000)
      axr(`IFT_ADDR_TX_TL);
      `CHK(rd, 32'h0000_0000)
      // corner codes first, then random words with reserved bits set
      for (int i = 0; i < 8; i++) begin
         case (i)
            0: d = 32'h0000_0000;
            1: d = 32'h0000_001F;
            2: d = 32'h0000_0020;
            3: d = 32'hFFFF_FFE5;
            default: d = $random(seed);
         endcase
         axw(`IFT_ADDR_RECEIVE_THRESHOLD_FIELD, d);
         axr(`IFT_ADDR_RECEIVE_THRESHOLD_FIELD);
         `CHK(rd, clamp(d))
         axw(`IFT_ADDR_TX_TL, ~d);
         axr(`IFT_ADDR_TX_TL);
         `CHK(rd, clamp(~d))
      end
      // sweep fill levels across each threshold, up then back down
      for (int k = 0; k < 5; k++) begin
         t = (k == 0) ? 0 : (k == 1) ? 31 : ($random(seed) & 31);
         axw(`IFT_ADDR_RECEIVE_THRESHOLD_FIELD, t);
         axw(`IFT_ADDR_TX_TL, t);
         for (int o = 0; o < 5; o++) begin
            l = t + offs[o];
            if (l >= 0 && l <= 32) begin
               lvl_set(l, l);
               `CHK(raw_intr_r[`IFT_B_RXL], rx_on(l, t))
               `CHK(raw_intr_r[`IFT_B_TXL], tx_on(l, t))
            end
         end
      end
      lvl_set(0, 0);
      lv = 16'h0014;
      // each clear register takes only its own flag
      for (int j = 0; j < 5; j++) begin
         pulse(5'h1F, 16'h0000);
         axr(clra[j]);
         `CHK(rd[31:1], 31'h0)
         `CHK(raw_intr_r & ~lv, 16'h006B & ~(16'h0001 << ((j == 0) ? 0 :
            (j == 1) ? 1 : (j == 2) ? 3 : (j == 3) ? 5 : 6)))
      end
      pulse(5'h1F, 16'h0000);
      bef = raw_intr_r & lv;
      axr(`IFT_ADDR_CLR_ALL);
      `CHK(raw_intr_r & ~lv, 16'h0000)
      `CHK(raw_intr_r & lv, bef)
      // abort source with and without the bit 9 hold
      for (int k = 0; k < 4; k++) begin
         abrt_keep <= k[0];
         pulse(5'h01, 16'h0200 | 16'($random(seed)));
         `CHK(tx_flush_r, 1'b1)
         axr(k[1] ? `IFT_ADDR_CLR_ALL : `IFT_ADDR_CLR_ABT);
         `CHK(abrt_src_r, k[0] ? 16'h0200 : 16'h0000)
         `CHK(raw_intr_r[`IFT_B_ABT], 1'b0)
         if (!k[1]) `CHK(tx_flush_r, 1'b0)
      end
      axr(`IFT_ADDR_CLR_ALL);
      // interrupt: masked, unmasked, then cleared by writing one
      axw(`IFT_ADDR_IRQ_STAT, 32'h0000_007F);
      axw(`IFT_ADDR_IRQ_MASK, 32'h0000_0000);
      pulse(5'h10, 16'h0000);
      `CHK(irq_r, 1'b0)
      axw(`IFT_ADDR_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      `CHK(irq_r, 1'b1)
      axw(`IFT_ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      `CHK(irq_r, 1'b0)
      axr(32'h5000_1500);
      `CHK(rs, `IFT_RESP_SLVERR)
      axw(32'h5000_1500, 32'h0000_0001);
      `CHK(rs, `IFT_RESP_SLVERR)
      test_done();
   end
endmodule

// File: verif/ift_eng_model.sv
module ift_eng_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] rx_tgt,
   input wire logic [5:0] tx_tgt,
   input wire logic tx_flush_r,
   output logic [5:0] rx_lvl,
   output logic [5:0] tx_lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // fifo fill levels
   // ----------------------------------------------------------------
   // receive fill walks one entry a cycle, never past 32
   always_ff @(posedge clk) begin
      if (!reset_n) rx_lvl <= 6'h00;
      else if (rx_lvl < rx_tgt && rx_lvl < 6'h20) rx_lvl <= rx_lvl + 6'h01;
      else if (rx_lvl > rx_tgt) rx_lvl <= rx_lvl - 6'h01;
   end
   // a flushed transmit fifo looks empty and takes no pushes
   always_ff @(posedge clk) begin
      if (!reset_n || tx_flush_r) tx_lvl <= 6'h00;
      else if (tx_lvl < tx_tgt && tx_lvl < 6'h20) tx_lvl <= tx_lvl + 6'h01;
      else if (tx_lvl > tx_tgt) tx_lvl <= tx_lvl - 6'h01;
   end
endmodule
